// ===== pkg/csub_pkg.sv
// constants shared by the channel status and user bit buffer block
// How it works
// - hold 384 status bits plus 384 user bits
// - host buffer feeds transmit buffer, transmit feeds encoder
// - blocks move only at output block boundaries
// - byte msb goes first; byte 0 at 0x20
// - host reads and writes host status buffer
// - pulse on each block move when enabled
// - inhibit suppresses all block moves
// - professional block gets hardware check byte
// - serial status input also gets check byte
// - every status bit read/modify/write; host sets copy bits
// - 24 words; upper byte first subframe, lower second
// - control bit selects one or two byte access
// - one byte read picks half by select
// - one byte write fills both halves
// - two byte read: first then second subframe
// - user mode 1 sends only zeros
// - user mode 2 double buffers host user data
// - user buffer always two byte access
// - user word interleaves first/second subframe bits msb first
// - reset clears all; operation waits for run
`default_nettype none
package csub_pkg;
	localparam int WORDS = 24; // words per block buffer
	localparam int FRAMES = 192; // frames per block
	localparam int STREAM_BITS = 184; // bits ahead of the check byte
	localparam logic [4:0] LAST_WORD = 5'h17; // word that carries the check byte
	localparam logic [6:0] CS_BASE = 7'h20; // status host buffer, byte 0
	localparam logic [6:0] CS_END = 7'h37; // status host buffer, last word
	localparam logic [6:0] U_BASE = 7'h40; // user host buffer, word 0
	localparam logic [6:0] U_END = 7'h57; // user host buffer, last word
	localparam logic [7:0] CRC_INIT = 8'hFF; // check byte preset
	localparam logic [7:0] CRC_POLY = 8'h1D; // x^8+x^4+x^3+x^2+1
	localparam logic [15:0] WORD_RESET = 16'h0000; // buffer word after reset
	localparam logic [7:0] BYTE_RESET = 8'h00; // byte registers after reset
	localparam logic [6:0] PTR_RESET = 7'h00; // access pointer after reset
endpackage : csub_pkg
`default_nettype wire

// ===== rtl/csub_crc8.sv
// check byte generator over the first 23 bytes of one status block
`default_nettype none
module csub_crc8 (
	input wire logic [183:0] i_data, // bytes 0..22, byte 0 msb at bit 183
	output logic [7:0] o_crc // resulting check byte
);
	// serial crc unrolled in transmit order, msb of byte 0 first
	always_comb begin
		logic [7:0] crc;
		logic fb;
		crc = csub_pkg::CRC_INIT;
		fb = 1'b0;
		for (int i = csub_pkg::STREAM_BITS - 1; i >= 0; i--) begin
			fb = crc[7] ^ i_data[i];
			crc = {crc[6:0], 1'b0} ^ (fb ? csub_pkg::CRC_POLY : 8'h00);
		end
		o_crc = crc;
	end
endmodule : csub_crc8
`default_nettype wire

// ===== rtl/csub_buffer.sv
// double block buffers for channel status and user bits with host access
`default_nettype none
module csub_buffer (
	input wire logic i_mclk, // master clock
	input wire logic i_reset, // async reset, high
	input wire logic i_run, // run control bit
	input wire logic i_inhibit, // host-to-transmit move inhibit
	input wire logic i_two_byte, // 1 = two byte access, 0 = one byte
	input wire logic i_read_b, // one byte read: 1 = second subframe half
	input wire logic i_user_block, // 1 = user mode 2, 0 = mode 1 zeros
	input wire logic i_int_en, // block move interrupt enable
	input wire logic i_hw_mode, // status bits come on the serial pin
	input wire logic i_copy_c, // serial status pin, asynchronous
	input wire logic i_addr_load, // load access pointer
	input wire logic [6:0] i_addr, // pointer value to load
	input wire logic i_wr_stb, // one written byte
	input wire logic [7:0] i_wdata, // written byte
	input wire logic i_rd_stb, // one read byte requested
	input wire logic i_block_start, // output block boundary from timebase
	input wire logic i_bit_stb, // encoder takes the bits of one frame
	input wire logic [7:0] i_frame_idx, // frame number within block
	output logic [7:0] o_rdata, // read byte
	output logic o_rd_valid, // read byte valid pulse
	output logic o_cs_a, // status bit, first subframe
	output logic o_cs_b, // status bit, second subframe
	output logic o_u_a, // user bit, first subframe
	output logic o_u_b, // user bit, second subframe
	output logic o_xfer_irq, // block move interrupt pulse
	output logic o_block_pro // transmitted first subframe block is professional
);
	// storage, flip-flops addressed by word index
	logic [15:0] cs_e [csub_pkg::WORDS]; // status host buffer, 384 bits
	logic [15:0] cs_f [csub_pkg::WORDS]; // status transmit buffer
	logic [15:0] u_e [csub_pkg::WORDS]; // user host buffer, 384 bits
	logic [15:0] u_f [csub_pkg::WORDS]; // user transmit buffer

	// access state
	logic [6:0] ptr_reg; // current access address
	logic phase_reg; // 0 = first byte of word, 1 = second
	logic run_reg; // run bit, registered copy of i_run
	logic c_meta_reg; // serial pin, first stage
	logic c_sync_reg; // serial pin, second stage

	// decode results
	logic in_cs; // pointer inside status buffer
	logic in_u; // pointer inside user buffer
	logic [4:0] widx; // word index within a buffer
	logic two_phase; // word takes two bytes
	logic last_byte; // this byte finishes the word
	logic cs_we_hi; // write status upper byte
	logic cs_we_lo; // write status lower byte
	logic u_we_hi; // write user upper byte
	logic u_we_lo; // write user lower byte
	logic [7:0] rd_byte; // byte selected for reading
	logic xfer; // block move this cycle
	logic hw_cap; // serial status capture this cycle
	logic [4:0] fword; // frame word index
	logic fvalid; // frame number inside the block
	logic [7:0] crc_a; // check byte, first subframe
	logic [7:0] crc_b; // check byte, second subframe
	logic pro_a; // first subframe block is professional
	logic pro_b; // second subframe block is professional
	logic [183:0] stream_a; // first subframe bytes 0..22
	logic [183:0] stream_b; // second subframe bytes 0..22

	// address decode of the access pointer
	always_comb begin
		in_cs = 1'b0;
		in_u = 1'b0;
		widx = 5'h00;
		if (ptr_reg >= csub_pkg::CS_BASE && ptr_reg <= csub_pkg::CS_END) begin
			in_cs = 1'b1;
			widx = 5'(ptr_reg - csub_pkg::CS_BASE);
		end else if (ptr_reg >= csub_pkg::U_BASE && ptr_reg <= csub_pkg::U_END) begin
			in_u = 1'b1;
			widx = 5'(ptr_reg - csub_pkg::U_BASE);
		end else begin
			in_cs = 1'b0; // unmapped: reads zero, writes dropped
		end
	end

	// bytes per word: user always two, status by mode bit
	assign two_phase = in_u | (in_cs & i_two_byte);
	assign last_byte = ~two_phase | phase_reg;

	// write enables for the halves of the addressed word
	always_comb begin
		cs_we_hi = 1'b0;
		cs_we_lo = 1'b0;
		u_we_hi = 1'b0;
		u_we_lo = 1'b0;
		if (i_wr_stb && in_cs && !i_hw_mode) begin
			if (!i_two_byte) begin
				cs_we_hi = 1'b1;
				cs_we_lo = 1'b1;
			end else begin
				cs_we_hi = ~phase_reg; // first byte to first subframe
				cs_we_lo = phase_reg; // second byte to second subframe
			end
		end else if (i_wr_stb && in_u) begin
			u_we_hi = ~phase_reg;
			u_we_lo = phase_reg;
		end
	end

	// read byte selection
	always_comb begin
		rd_byte = csub_pkg::BYTE_RESET;
		if (in_cs) begin
			if (!i_two_byte) begin
				rd_byte = i_read_b ? cs_e[widx][7:0] : cs_e[widx][15:8];
			end else begin
				rd_byte = phase_reg ? cs_e[widx][7:0] : cs_e[widx][15:8];
			end
		end else if (in_u) begin
			rd_byte = phase_reg ? u_e[widx][7:0] : u_e[widx][15:8];
		end
	end

	// access pointer and byte phase, auto-increment per finished word
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			ptr_reg <= csub_pkg::PTR_RESET;
			phase_reg <= 1'b0;
		end else if (i_addr_load) begin
			ptr_reg <= i_addr;
			phase_reg <= 1'b0;
		end else if (i_wr_stb || i_rd_stb) begin
			if (last_byte) begin
				ptr_reg <= ptr_reg + 7'h01;
				phase_reg <= 1'b0;
			end else begin
				phase_reg <= 1'b1; // second byte of the same word
			end
		end
	end

	// read data register
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_rdata <= csub_pkg::BYTE_RESET;
			o_rd_valid <= 1'b0;
		end else begin
			o_rd_valid <= i_rd_stb;
			if (i_rd_stb) begin
				o_rdata <= rd_byte;
			end
		end
	end

	// run bit, operation only after the host sets it
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			run_reg <= 1'b0;
		end else begin
			run_reg <= i_run;
		end
	end

	// serial status pin synchroniser
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			c_meta_reg <= 1'b0;
			c_sync_reg <= 1'b0;
		end else begin
			c_meta_reg <= i_copy_c;
			c_sync_reg <= c_meta_reg;
		end
	end

	// frame position decode for capture and transmit
	assign fword = i_frame_idx[7:3];
	assign fvalid = (i_frame_idx < 8'(csub_pkg::FRAMES));
	assign hw_cap = i_hw_mode & i_bit_stb & fvalid & run_reg;

	// move only on a boundary, running and not inhibited
	assign xfer = i_block_start & run_reg & ~i_inhibit;

	// professional flags are the msb of byte 0 of each subframe block
	assign pro_a = cs_e[0][15];
	assign pro_b = cs_e[0][7];

	// gather bytes 0..22 of each subframe block for the check byte
	generate
		for (genvar s = 0; s < csub_pkg::WORDS - 1; s++) begin : g_stream
			assign stream_a[183 - 8 * s -: 8] = cs_e[s][15:8];
			assign stream_b[183 - 8 * s -: 8] = cs_e[s][7:0];
		end
	endgenerate

	// check byte generators, one per subframe block
	csub_crc8 u_crc_a (
		.i_data(stream_a),
		.o_crc(crc_a)
	);
	csub_crc8 u_crc_b (
		.i_data(stream_b),
		.o_crc(crc_b)
	);

	// per word storage: host writes, serial capture, block moves
	generate
		for (genvar w = 0; w < csub_pkg::WORDS; w++) begin : g_word
			// status host buffer word
			always_ff @(posedge i_mclk or posedge i_reset) begin
				if (i_reset) begin
					cs_e[w] <= csub_pkg::WORD_RESET;
				end else if (hw_cap && fword == 5'(w)) begin
					cs_e[w][{1'b1, ~i_frame_idx[2:0]}] <= c_sync_reg;
					cs_e[w][{1'b0, ~i_frame_idx[2:0]}] <= c_sync_reg;
				end else if (widx == 5'(w)) begin
					if (cs_we_hi) begin
						cs_e[w][15:8] <= i_wdata;
					end
					if (cs_we_lo) begin
						cs_e[w][7:0] <= i_wdata;
					end
				end
			end

			// status transmit buffer word, loaded from host buffer; word 23 takes the check byte in each professional half
			always_ff @(posedge i_mclk or posedge i_reset) begin
				if (i_reset) begin
					cs_f[w] <= csub_pkg::WORD_RESET;
				end else if (xfer) begin
					if (5'(w) == csub_pkg::LAST_WORD) begin
						cs_f[w][15:8] <= pro_a ? crc_a : cs_e[w][15:8];
						cs_f[w][7:0] <= pro_b ? crc_b : cs_e[w][7:0];
					end else begin
						cs_f[w] <= cs_e[w];
					end
				end
			end

			// user host buffer word
			always_ff @(posedge i_mclk or posedge i_reset) begin
				if (i_reset) begin
					u_e[w] <= csub_pkg::WORD_RESET;
				end else if (widx == 5'(w)) begin
					if (u_we_hi) begin
						u_e[w][15:8] <= i_wdata;
					end
					if (u_we_lo) begin
						u_e[w][7:0] <= i_wdata;
					end
				end
			end

			// user transmit buffer word, moved with the status block in mode 2 only
			always_ff @(posedge i_mclk or posedge i_reset) begin
				if (i_reset) begin
					u_f[w] <= csub_pkg::WORD_RESET;
				end else if (xfer && i_user_block) begin
					u_f[w] <= u_e[w];
				end
			end
		end
	endgenerate

	// block move interrupt pulse
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_xfer_irq <= 1'b0;
		end else begin
			o_xfer_irq <= xfer & i_int_en;
		end
	end

	// professional flag of the first subframe block now in the transmit buffer
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_block_pro <= 1'b0;
		end else begin
			o_block_pro <= cs_f[0][15];
		end
	end

	// status bits to the encoder, only from the transmit buffer
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_cs_a <= 1'b0;
			o_cs_b <= 1'b0;
		end else if (!run_reg) begin
			o_cs_a <= 1'b0; // outputs quiet until run
			o_cs_b <= 1'b0;
		end else if (i_bit_stb && fvalid) begin
			o_cs_a <= cs_f[fword][{1'b1, ~i_frame_idx[2:0]}]; // msb first
			o_cs_b <= cs_f[fword][{1'b0, ~i_frame_idx[2:0]}];
		end
	end

	// user bits to the encoder, zeros in mode 1
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_u_a <= 1'b0;
			o_u_b <= 1'b0;
		end else if (!run_reg || !i_user_block) begin
			o_u_a <= 1'b0;
			o_u_b <= 1'b0;
		end else if (i_bit_stb && fvalid) begin
			o_u_a <= u_f[fword][{~i_frame_idx[2:0], 1'b1}];
			o_u_b <= u_f[fword][{~i_frame_idx[2:0], 1'b0}];
		end
	end

	// storage sizing: 24 x 16 bits in each of the four buffers
endmodule : csub_buffer
`default_nettype wire

// ===== verification/csub_chk.sv
// port checker for the status and user bit buffers
`default_nettype none
module csub_chk (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_run,
	input wire logic i_inhibit,
	input wire logic i_int_en,
	input wire logic i_user_block,
	input wire logic i_addr_load,
	input wire logic [6:0] i_addr,
	input wire logic i_rd_stb,
	input wire logic i_block_start,
	input wire logic i_bit_stb,
	input wire logic [7:0] i_frame_idx,
	input wire logic [7:0] o_rdata,
	input wire logic o_rd_valid,
	input wire logic o_cs_a,
	input wire logic o_cs_b,
	input wire logic o_u_a,
	input wire logic o_u_b,
	input wire logic o_xfer_irq
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_reset);
	// read request, then its answer
	sequence rd_s; i_rd_stb && !i_addr_load; endsequence
	sequence ans_s; o_rd_valid; endsequence
	// pointer loaded to an unmapped place, then read
	sequence void_s;
		i_addr_load && (i_addr < 7'h20 || (i_addr > 7'h37 && i_addr < 7'h40) || i_addr > 7'h57)
		##1 rd_s;
	endsequence
	// boundary while running and not inhibited
	sequence move_s; i_block_start && !i_inhibit && $past(i_run) && !$past(i_reset); endsequence
	read_answer_a: assert property (rd_s |=> ans_s) else $error("read not answered");
	read_quiet_a: assert property (!i_rd_stb |=> !o_rd_valid) else $error("stray valid");
	read_hold_a: assert property (!i_rd_stb |=> $stable(o_rdata)) else $error("rdata moved");
	void_read_a: assert property (void_s |=> o_rdata == 8'h00) else $error("unmapped data");
	move_irq_a: assert property ((move_s and i_int_en) |=> o_xfer_irq) else $error("no irq");
	irq_quiet_a: assert property (!(i_block_start && !i_inhibit && i_int_en) |=> !o_xfer_irq)
		else $error("irq without move");
	user_zero_a: assert property (i_bit_stb && !i_user_block && i_frame_idx < 8'hC0 |=>
		!o_u_a && !o_u_b) else $error("user bit in zero mode");
	idle_bits_a: assert property (i_bit_stb && !$past(i_run) |=>
		!o_cs_a && !o_cs_b && !o_u_a && !o_u_b) else $error("bits while stopped");
endmodule : csub_chk
`default_nettype wire

// ===== verification/csub_host.sv
// host model on the byte port, also holding the move inhibit
`default_nettype none
module csub_host (
	input wire logic i_mclk,
	input wire logic [7:0] i_rdata,
	output logic o_load,
	output logic [6:0] o_addr,
	output logic o_wr,
	output logic [7:0] o_wdata,
	output logic o_rd,
	output logic o_inhibit
);
	timeunit 1ns;
	timeprecision 100ps;
	// idle port at time zero
	initial begin
		o_load = 1'h0;
		o_addr = 7'h00;
		o_wr = 1'h0;
		o_wdata = 8'h00;
		o_rd = 1'h0;
		o_inhibit = 1'h0;
	end
	// one port cycle; unqualified lines show garbage
	task automatic xfer(input logic ld, input logic wr, input logic rd, input logic [7:0] v);
		o_load = ld;
		o_addr = ld ? v[6:0] : ~v[6:0];
		o_wr = wr;
		o_wdata = wr ? v : ~v;
		o_rd = rd;
		@(posedge i_mclk);
		#1;
	endtask : xfer
	// inhibit level
	task automatic hold(input logic v);
		o_inhibit = v;
	endtask : hold
	// whole block burst write under inhibit
	task automatic put_blk(input logic [6:0] base, input logic two, input logic [15:0] w [24]);
		o_inhibit = 1'h1; // long burst keeps moves off
		xfer(1'h1, 1'h0, 1'h0, {1'h0, base});
		for (int i = 0; i < 24; i++) begin
			xfer(1'h0, 1'h1, 1'h0, w[i][15:8]); // first subframe byte first
			if (two)
				xfer(1'h0, 1'h1, 1'h0, w[i][7:0]);
		end
		o_inhibit = 1'h0;
		xfer(1'h0, 1'h0, 1'h0, 8'h00);
	endtask : put_blk
	// whole block two byte read
	task automatic get_blk(input logic [6:0] base, output logic [15:0] w [24]);
		xfer(1'h1, 1'h0, 1'h0, {1'h0, base});
		for (int i = 0; i < 24; i++) begin
			xfer(1'h0, 1'h0, 1'h1, 8'h00);
			w[i][15:8] = i_rdata;
			xfer(1'h0, 1'h0, 1'h1, 8'h00);
			w[i][7:0] = i_rdata;
		end
		xfer(1'h0, 1'h0, 1'h0, 8'h00);
	endtask : get_blk
endmodule : csub_host
`default_nettype wire

// ===== verification/csub_buffer_test.sv
// self-checking bench for the status and user bit buffers
`default_nettype none
module csub_buffer_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_mclk, i_reset, i_run, i_inhibit, i_two_byte, i_read_b, i_user_block, i_int_en;
	logic i_hw_mode, i_copy_c, i_addr_load, i_wr_stb, i_rd_stb, i_block_start, i_bit_stb;
	logic [6:0] i_addr;
	logic [7:0] i_wdata, i_frame_idx, o_rdata;
	logic o_rd_valid, o_cs_a, o_cs_b, o_u_a, o_u_b, o_xfer_irq, o_block_pro;
	logic [15:0] e_cs [24], f_cs [24], e_u [24], f_u [24]; // expected host and transmit blocks
	int failures = 0;
	int total_checks = 0;
	int cycles = 0;
	csub_buffer csub_buffer_i (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_run(i_run),
		.i_inhibit(i_inhibit),
		.i_two_byte(i_two_byte),
		.i_read_b(i_read_b),
		.i_user_block(i_user_block),
		.i_int_en(i_int_en),
		.i_hw_mode(i_hw_mode),
		.i_copy_c(i_copy_c),
		.i_addr_load(i_addr_load),
		.i_addr(i_addr),
		.i_wr_stb(i_wr_stb),
		.i_wdata(i_wdata),
		.i_rd_stb(i_rd_stb),
		.i_block_start(i_block_start),
		.i_bit_stb(i_bit_stb),
		.i_frame_idx(i_frame_idx),
		.o_rdata(o_rdata),
		.o_rd_valid(o_rd_valid),
		.o_cs_a(o_cs_a),
		.o_cs_b(o_cs_b),
		.o_u_a(o_u_a),
		.o_u_b(o_u_b),
		.o_xfer_irq(o_xfer_irq),
		.o_block_pro(o_block_pro)
	);
	csub_host csub_host_i (.i_mclk(i_mclk), .i_rdata(o_rdata), .o_load(i_addr_load),
		.o_addr(i_addr), .o_wr(i_wr_stb), .o_wdata(i_wdata), .o_rd(i_rd_stb),
		.o_inhibit(i_inhibit));
	// clock and hang guard
	initial begin
		i_mclk = 1'h0;
		forever #20 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			give_verdict();
		end
	end
	task automatic cyc();
		@(posedge i_mclk);
		#1;
	endtask : cyc
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic give_verdict();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict
	// check byte over bytes 0..22 of one subframe, msb first
	function automatic logic [7:0] crc_of(input logic hi);
		logic [7:0] c;
		logic [7:0] b;
		c = csub_pkg::CRC_INIT;
		for (int i = 0; i < 23; i++) begin
			b = hi ? f_cs[i][15:8] : f_cs[i][7:0];
			for (int j = 7; j >= 0; j--)
				c = {c[6:0], 1'h0} ^ ((c[7] ^ b[j]) ? csub_pkg::CRC_POLY : 8'h00);
		end
		return c;
	endfunction : crc_of
	// one boundary pulse; model the block move
	task automatic move(input logic go);
		i_block_start = 1'h1;
		cyc();
		check("irq", 16'(o_xfer_irq), 16'(go & i_int_en));
		i_block_start = 1'h0;
		cyc();
		check("irq_end", 16'(o_xfer_irq), 16'h0000);
		if (go) begin
			f_cs = e_cs;
			if (i_user_block)
				f_u = e_u;
		end
	endtask : move
	// walk all frames and compare the four bit outputs
	task automatic scan();
		logic [15:0] x;
		logic [15:0] u;
		for (int f = 0; f < 192; f++) begin
			i_frame_idx = 8'(f);
			i_bit_stb = 1'h1;
			cyc();
			x = f_cs[f / 8];
			u = i_user_block ? f_u[f / 8] : 16'h0000;
			if (f / 8 == 23 && f_cs[0][15])
				x[15:8] = crc_of(1'h1);
			if (f / 8 == 23 && f_cs[0][7])
				x[7:0] = crc_of(1'h0);
			check("cs", 16'({o_cs_a, o_cs_b}),
				16'({x[15 - f % 8], x[7 - f % 8]}));
			check("u", 16'({o_u_a, o_u_b}),
				16'({u[15 - 2 * (f % 8)], u[14 - 2 * (f % 8)]}));
		end
		i_bit_stb = 1'h0;
	endtask : scan
	task automatic cmp_blk(input logic [6:0] base, input logic [15:0] w [24]);
		logic [15:0] got [24];
		csub_host_i.get_blk(base, got);
		for (int i = 0; i < 24; i++)
			check("word", got[i], w[i]);
	endtask : cmp_blk
	// all clear after reset
	task automatic t_reset();
		check("outs", 16'({o_rdata, o_rd_valid, o_cs_a, o_cs_b, o_u_a, o_u_b, o_xfer_irq}),
			16'h0000);
		move(1'h0);
		i_bit_stb = 1'h1; // frame request while stopped
		cyc();
		i_bit_stb = 1'h0;
		check("stopped", 16'({o_cs_a, o_cs_b, o_u_a, o_u_b}), 16'h0000);
		i_run = 1'h1;
		cyc();
		cmp_blk(csub_pkg::CS_BASE, f_cs);
	endtask : t_reset
	// two byte block, inhibited then released move
	task automatic t_status();
		for (int i = 0; i < 24; i++)
			e_cs[i] = {8'(i) * 8'h0B, 8'(i) * 8'h05 + 8'h30};
		csub_host_i.put_blk(csub_pkg::CS_BASE, 1'h1, e_cs);
		csub_host_i.hold(1'h1);
		move(1'h0);
		csub_host_i.hold(1'h0);
		move(1'h1);
		cmp_blk(csub_pkg::CS_BASE, e_cs);
		scan();
		check("pro", 16'(o_block_pro), 16'h0000);
	endtask : t_status
	// one byte writes fill both halves; reads pick a half
	task automatic t_one();
		i_two_byte = 1'h0;
		csub_host_i.xfer(1'h1, 1'h0, 1'h0, 8'h25);
		csub_host_i.xfer(1'h0, 1'h1, 1'h0, 8'h9C);
		csub_host_i.xfer(1'h0, 1'h1, 1'h0, 8'h3A);
		e_cs[5] = 16'h9C9C;
		e_cs[6] = 16'h3A3A;
		for (int rb = 1; rb >= 0; rb--) begin
			i_read_b = 1'(rb);
			csub_host_i.xfer(1'h1, 1'h0, 1'h0, 8'h25);
			csub_host_i.xfer(1'h0, 1'h0, 1'h1, 8'h00);
			check("one_a", 16'(o_rdata), 16'h009C);
			check("valid", 16'(o_rd_valid), 16'h0001);
			csub_host_i.xfer(1'h0, 1'h0, 1'h1, 8'h00);
			check("one_b", 16'(o_rdata), 16'h003A);
		end
		csub_host_i.xfer(1'h1, 1'h0, 1'h0, 8'h38);
		csub_host_i.xfer(1'h0, 1'h0, 1'h1, 8'h00);
		check("unmapped", 16'(o_rdata), 16'h0000);
		csub_host_i.xfer(1'h0, 1'h0, 1'h0, 8'h00);
		i_two_byte = 1'h1;
		cmp_blk(csub_pkg::CS_BASE, e_cs);
	endtask : t_one
	// professional first subframe gets its check byte
	task automatic t_pro();
		e_cs[0][15] = 1'h1;
		csub_host_i.put_blk(csub_pkg::CS_BASE, 1'h1, e_cs);
		move(1'h1);
		check("pro", 16'(o_block_pro), 16'h0001);
		scan();
	endtask : t_pro
	// hardware mode: serial pin fills the host buffer, host writes dropped
	task automatic t_hw();
		i_hw_mode = 1'h1;
		i_copy_c = 1'h1;
		cyc();
		cyc(); // pin through both sync stages
		scan(); // every frame captures a one
		csub_host_i.xfer(1'h1, 1'h0, 1'h0, 8'h20);
		csub_host_i.xfer(1'h0, 1'h1, 1'h0, 8'h00); // dropped in hardware mode
		csub_host_i.xfer(1'h0, 1'h0, 1'h0, 8'h00);
		for (int i = 0; i < 24; i++)
			e_cs[i] = 16'hFFFF;
		i_int_en = 1'h0;
		move(1'h1); // move with interrupt off
		i_int_en = 1'h1;
		scan(); // both halves professional, check bytes
		i_two_byte = 1'h1;
		cmp_blk(csub_pkg::CS_BASE, e_cs);
		i_hw_mode = 1'h0;
	endtask : t_hw
	// user block in two byte form whatever the mode bit
	task automatic t_user();
		i_two_byte = 1'h0;
		for (int i = 0; i < 24; i++)
			e_u[i] = {8'(i) * 8'h13, 8'hA5 ^ 8'(i)};
		csub_host_i.put_blk(csub_pkg::U_BASE, 1'h1, e_u);
		i_user_block = 1'h1;
		move(1'h1);
		scan();
		i_user_block = 1'h0;
		scan();
		cmp_blk(csub_pkg::U_BASE, e_u);
	endtask : t_user
	initial begin
		{i_run, i_two_byte, i_read_b, i_user_block, i_hw_mode, i_copy_c} = 6'h00;
		{i_block_start, i_bit_stb, i_frame_idx} = 10'h000;
		i_int_en = 1'h1;
		i_reset = 1'h1;
		for (int i = 0; i < 24; i++) begin
			f_cs[i] = 16'h0000;
			f_u[i] = 16'h0000;
			e_u[i] = 16'h0000;
		end
		e_cs = f_cs;
		repeat (4) @(posedge i_mclk);
		#1;
		i_reset = 1'h0;
		i_two_byte = 1'h1;
		t_reset();
		t_status();
		t_one();
		t_pro();
		t_user();
		t_hw();
		give_verdict();
	end
endmodule : csub_buffer_test
bind csub_buffer csub_chk csub_chk_i (
	.i_mclk(i_mclk),
	.i_reset(i_reset),
	.i_run(i_run),
	.i_inhibit(i_inhibit),
	.i_int_en(i_int_en),
	.i_user_block(i_user_block),
	.i_addr_load(i_addr_load),
	.i_addr(i_addr),
	.i_rd_stb(i_rd_stb),
	.i_block_start(i_block_start),
	.i_bit_stb(i_bit_stb),
	.i_frame_idx(i_frame_idx),
	.o_rdata(o_rdata),
	.o_rd_valid(o_rd_valid),
	.o_cs_a(o_cs_a),
	.o_cs_b(o_cs_b),
	.o_u_a(o_u_a),
	.o_u_b(o_u_b),
	.o_xfer_irq(o_xfer_irq)
);
`default_nettype wire
